// file: rtl/brss_regs.svh
// constants for the bridge reset strap and select block
`ifndef BRSS_REGS_SVH
`define BRSS_REGS_SVH
`define BRSS_TEST_NORMAL   2'h0
`define BRSS_TEST_TRISTATE 2'h1
`define BRSS_TEST_NAND     2'h2
`define BRSS_ACK_DELAY     4'h2
`define BRSS_SYNC_ONES     2'h3
`endif

// file: rtl/brss_pkg.sv
// types for the bridge reset strap and select block
package brss_pkg;
  // captured strap set
  typedef struct packed {
    logic       family_one_mode;
    logic       eeprom_load;
    logic [1:0] test_config;
    logic       initiator_enable;
    logic       arbiter_enable;
    logic       link_off;
  } brss_strap_type;

  typedef enum logic [1:0] {
    BRSS_SEL_NONE   = 2'b00,
    BRSS_SEL_REGS   = 2'b01,
    BRSS_SEL_IMAGE0 = 2'b10,
    BRSS_SEL_IMAGE1 = 2'b11
  } brss_target_type;

  typedef enum logic [1:0] {
    BRSS_IDLE = 2'b00,
    BRSS_WAIT = 2'b01,
    BRSS_ACK  = 2'b10,
    BRSS_HOLD = 2'b11
  } brss_cycle_type;
endpackage : brss_pkg

// file: rtl/brss_top.sv
// reset, strap capture and local chip select decode of the bridge
//
// Function
// - capture straps on PCI reset rise, local reset rise, hot-swap good fall
// - burst strap and size bit one both high select first processor family
// - test strap zero is normal; other codes tri-state or NAND-tree outputs
// - master enable strap high during PCI reset sets initiator enable bit
// - arbiter enable strap high at reset release enables internal arbiter
// - link-off strap high at release retries targets until flag cleared
// - bus bits numbered with highest index most significant
// - device terminates every cycle under either chip select itself
// - bursts accepted on window select; processor inhibits register bursts
// - local reset output asserted by PCI reset or software reset bit
// - PCI reset resets the cycle decode and termination logic and loads initiator enable from the master strap
// - window select routes to image 0 when image select low, else image 1
`timescale 1ns/100ps
`include "brss_regs.svh"
module brss_top #(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // reset sources
  input  wire logic                        pci_reset_n,
  input  wire logic                        local_reset_input_n,
  input  wire logic                        hot_swap_good_n,
  input  wire logic                        software_reset_bit,
  // strap pins
  input  wire logic                        burst_data_strap,
  input  wire logic                        transfer_size_bit_one,
  input  wire logic                        eeprom_load_strap,
  input  wire logic [1:0]                  test_config_strap,
  input  wire logic                        master_enable_strap,
  input  wire logic                        arbiter_enable_strap,
  input  wire logic                        host_link_off_strap,
  // software controls
  input  wire logic                        initiator_enable_write,
  input  wire logic                        initiator_enable_value,
  input  wire logic                        link_off_clear,
  // local bus cycle
  input  wire logic                        cycle_start,
  input  wire logic                        burst_last,
  input  wire logic                        register_chip_select_n,
  input  wire logic                        window_chip_select_n,
  input  wire logic                        image_select,
  input  wire logic [ADDR_W-1:0]           local_addr,
  input  wire logic                        address_strobe_input,
  input  wire logic                        first_size_ack_input,
  // reset and configuration outputs
  output logic                             local_reset_output_n,
  output brss_pkg::brss_strap_type         strap_state,
  output logic                             initiator_enable_bit,
  output logic                             link_off_flag,
  output logic                             pci_target_retry,
  output logic                             outputs_float,
  output logic                             nand_tree_mode,
  // local bus answer
  output brss_pkg::brss_target_type        target_sel,
  output logic [ADDR_W-1:0]                target_addr,
  output logic                             cycle_ack_n,
  output logic                             reg_burst_error
);

  // ----------------------------------------------------------------
  // reset event detection
  // ----------------------------------------------------------------
  logic pci_reset_n_reg;
  logic local_reset_n_reg;
  logic hs_good_n_reg;
  wire  pci_rise    = pci_reset_n & ~pci_reset_n_reg;
  wire  local_rise  = local_reset_input_n & ~local_reset_n_reg;
  wire  hs_fall     = ~hot_swap_good_n & hs_good_n_reg;
  wire  capture_now = pci_rise | local_rise | hs_fall;
  // pci reset is the global reset for the cycle decode and termination logic below
  wire  global_rst  = rst | ~pci_reset_n;

  // edge history resets high so a reset pin held high since power-up is no rise; a hot-swap pin held low is a fall
  always_ff @(posedge clk) begin
    if (rst) begin
      pci_reset_n_reg   <= 1'b1;
      local_reset_n_reg <= 1'b1;
      hs_good_n_reg     <= 1'b1;
    end else begin
      pci_reset_n_reg   <= pci_reset_n;
      local_reset_n_reg <= local_reset_input_n;
      hs_good_n_reg     <= hot_swap_good_n;
    end
  end

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  brss_pkg::brss_strap_type strap_reg;
  brss_pkg::brss_strap_type strap_next;
  assign strap_next.family_one_mode  = burst_data_strap & transfer_size_bit_one;
  assign strap_next.eeprom_load      = eeprom_load_strap;
  assign strap_next.test_config      = test_config_strap;
  assign strap_next.initiator_enable = master_enable_strap;
  assign strap_next.arbiter_enable   = arbiter_enable_strap;
  assign strap_next.link_off         = host_link_off_strap;

  // straps move only on a reset event and are frozen otherwise
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_reg <= '0;
    end else if (capture_now) begin
      strap_reg <= strap_next;
    end
  end

  // ----------------------------------------------------------------
  // initiator enable and link-off status
  // ----------------------------------------------------------------
  logic initiator_reg;
  logic link_off_reg;
  // pci reset clears the bit unless the master strap is high; software may write it later
  wire  initiator_next = ~pci_reset_n ? master_enable_strap :
                         initiator_enable_write ? initiator_enable_value :
                         initiator_reg;
  // release capture sets the flag; set wins over a clear in the same cycle
  wire  link_off_next  = (capture_now & host_link_off_strap) ? 1'b1 :
                         link_off_clear ? 1'b0 : link_off_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      initiator_reg <= 1'b0;
      link_off_reg  <= 1'b0;
    end else begin
      initiator_reg <= initiator_next;
      link_off_reg  <= link_off_next;
    end
  end

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  wire test_tri  = strap_reg.test_config == `BRSS_TEST_TRISTATE;
  wire test_nand = strap_reg.test_config == `BRSS_TEST_NAND;
  // tri-state code and code three float outputs; the NAND code does not
  wire float_n   = strap_reg.test_config != `BRSS_TEST_NORMAL;

  always_ff @(posedge clk) begin
    if (rst) begin
      local_reset_output_n <= 1'b0;
      strap_state          <= '0;
      initiator_enable_bit <= 1'b0;
      link_off_flag        <= 1'b0;
      pci_target_retry     <= 1'b0;
      outputs_float        <= 1'b0;
      nand_tree_mode       <= 1'b0;
    end else begin
      local_reset_output_n <= pci_reset_n & ~software_reset_bit;
      strap_state          <= strap_reg;
      initiator_enable_bit <= initiator_reg;
      link_off_flag        <= link_off_reg;
      pci_target_retry     <= link_off_reg;
      outputs_float        <= float_n & (test_tri | ~test_nand);
      nand_tree_mode       <= test_nand;
    end
  end

  // ----------------------------------------------------------------
  // chip select decode and cycle termination
  // ----------------------------------------------------------------
  // address index 31 is most significant on both sides, passed as is
  wire reg_hit = ~register_chip_select_n;
  wire win_hit = ~window_chip_select_n;
  brss_pkg::brss_target_type decode_sel;
  assign decode_sel = win_hit ? (image_select ? brss_pkg::BRSS_SEL_IMAGE1
                                              : brss_pkg::BRSS_SEL_IMAGE0)
                    : reg_hit ? brss_pkg::BRSS_SEL_REGS : brss_pkg::BRSS_SEL_NONE;
  // the family-one strobes are unused and held high by the board
  wire legacy_idle = address_strobe_input & first_size_ack_input;
  wire take_cycle  = cycle_start & (reg_hit | win_hit) & legacy_idle;

  brss_pkg::brss_cycle_type state_reg;
  brss_pkg::brss_cycle_type state_next;
  logic [3:0]               wait_reg;
  logic                     burst_reg;

  // fixed wait then one ack per beat; window bursts keep acking until last
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      brss_pkg::BRSS_IDLE: if (take_cycle) state_next = brss_pkg::BRSS_WAIT;
      brss_pkg::BRSS_WAIT: if (wait_reg == `BRSS_ACK_DELAY) state_next = brss_pkg::BRSS_ACK;
      brss_pkg::BRSS_ACK:  state_next = (burst_reg & ~burst_last) ? brss_pkg::BRSS_HOLD
                                                               : brss_pkg::BRSS_IDLE;
      brss_pkg::BRSS_HOLD: state_next = brss_pkg::BRSS_ACK;
    endcase
  end

  always_ff @(posedge clk) begin
    if (global_rst) begin
      state_reg       <= brss_pkg::BRSS_IDLE;
      wait_reg        <= '0;
      burst_reg       <= 1'b0;
      target_sel      <= brss_pkg::BRSS_SEL_NONE;
      target_addr     <= '0;
      cycle_ack_n     <= 1'b1;
      reg_burst_error <= 1'b0;
    end else begin
      state_reg   <= state_next;
      wait_reg    <= (state_reg == brss_pkg::BRSS_WAIT) ? wait_reg + 4'h1 : '0;
      cycle_ack_n <= ~(state_next == brss_pkg::BRSS_ACK);
      if (take_cycle && state_reg == brss_pkg::BRSS_IDLE) begin
        target_sel   <= decode_sel;
        target_addr  <= local_addr;
        burst_reg    <= win_hit & ~burst_last;
      end
      // a burst attempt on the register select is flagged, not followed
      reg_burst_error <= take_cycle & ~win_hit & ~burst_last;
    end
  end
endmodule : brss_top

// file: bench/brss_checker_properties.sv
// concurrent checks on the ports of the reset strap and select block
`timescale 1ns/100ps
module brss_checker #(
  parameter int ADDR_W = 32
) (
  // clock and reset
  input wire logic                     clk, rst,
  // reset sources and straps
  input wire logic                     pci_reset_n, local_reset_input_n, hot_swap_good_n,
  input wire logic                     software_reset_bit, burst_data_strap,
  input wire logic                     transfer_size_bit_one, arbiter_enable_strap,
  input wire logic                     host_link_off_strap, initiator_enable_write,
  // local cycle request
  input wire logic                     cycle_start, register_chip_select_n, image_select,
  input wire logic                     window_chip_select_n, address_strobe_input,
  input wire logic                     first_size_ack_input,
  input wire logic [ADDR_W-1:0]        local_addr,
  // outputs watched
  input wire logic                     local_reset_output_n, link_off_flag, pci_target_retry,
  input wire brss_pkg::brss_strap_type strap_state,
  input wire brss_pkg::brss_target_type target_sel,
  input wire logic [ADDR_W-1:0]        target_addr,
  input wire logic                     cycle_ack_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // a cycle is taken only with strobes parked high and the global reset released
  wire take = cycle_start && cycle_ack_n && pci_reset_n && address_strobe_input
              && first_size_ack_input && !(register_chip_select_n && window_chip_select_n);
  wire take_w = take && register_chip_select_n;
  a_ack_delay: assert property (take |-> ##[4:5] !cycle_ack_n)
    else $error("cycle not terminated by the block in time");
  a_ack_pulse: assert property (!cycle_ack_n |=> cycle_ack_n)
    else $error("termination held longer than one cycle");
  a_sel_regs: assert property (take && !register_chip_select_n |-> ##2
    target_sel == brss_pkg::BRSS_SEL_REGS) else $error("register select not routed");
  a_sel_image: assert property (take_w |-> ##2 target_sel[1]
    && target_sel[0] == $past(image_select, 2)) else $error("wrong slave image chosen");
  a_addr_pass: assert property (take |-> ##2 target_addr == $past(local_addr, 2))
    else $error("address bits reordered");
  a_reset_out: assert property (!pci_reset_n || software_reset_bit |=> !local_reset_output_n)
    else $error("local reset output not asserted");
  a_retry_follow: assert property (1'b1 |-> pci_target_retry == link_off_flag)
    else $error("retry does not follow the link-off flag");
  a_strap_capture: assert property ($rose(pci_reset_n) || $rose(local_reset_input_n)
    || $fell(hot_swap_good_n) |=> ##1
    strap_state.arbiter_enable == $past(arbiter_enable_strap, 2)
    && strap_state.link_off == $past(host_link_off_strap, 2)
    && strap_state.family_one_mode == $past(burst_data_strap && transfer_size_bit_one, 2))
    else $error("straps not captured at the reset event");
  a_strap_hold: assert property (pci_reset_n && $past(pci_reset_n) && !initiator_enable_write
    && !$rose(local_reset_input_n) && !$fell(hot_swap_good_n) |=> ##1 $stable({
    strap_state.family_one_mode, strap_state.test_config, strap_state.arbiter_enable}))
    else $error("captured straps moved between reset events");
  c_reg_cycle: cover property (take && !register_chip_select_n);
  c_image_one: cover property (take_w && image_select);
  c_hot_swap: cover property ($fell(hot_swap_good_n));
endmodule : brss_checker

bind brss_top brss_checker #(.ADDR_W(ADDR_W)) u_brss_checker (.*);

// file: bench/brss_cpu_model.sv
// processor side model that runs single-beat decoded local cycles
`timescale 1ns/100ps
module brss_cpu_model #(
  parameter int ADDR_W = 32
) (
  // clock and answer
  input  wire logic         clk, cycle_ack_n,
  // decoded cycle request
  output logic              cycle_start, burst_last, image_select,
  output logic              register_chip_select_n, window_chip_select_n,
  output logic [ADDR_W-1:0] local_addr,
  // strobes unused by this processor family
  output logic              address_strobe_input, first_size_ack_input
);
  // idle bus; unused strobes parked high
  initial begin
    {cycle_start, image_select, local_addr} = '0;
    {register_chip_select_n, window_chip_select_n} = 2'h3;
    burst_last = 1'b1;
    {address_strobe_input, first_size_ack_input} = 2'h3;
  end
  // one cycle; start pulsed one clock, selects and address held until termination or 12 clocks of waiting, then address lines show garbage
  task automatic run(input logic to_regs, input logic img, input logic [ADDR_W-1:0] a,
                     output int waited);
    waited = 0;
    @(posedge clk);
    cycle_start <= 1'b1;
    register_chip_select_n <= !to_regs;
    window_chip_select_n <= to_regs;
    image_select <= img;
    local_addr <= a;
    @(posedge clk);
    cycle_start <= 1'b0;
    do begin
      @(posedge clk);
      waited++;
    end while (cycle_ack_n !== 1'b0 && waited < 12);
    {register_chip_select_n, window_chip_select_n} <= 2'h3;
    local_addr <= ~a;
  endtask : run
endmodule : brss_cpu_model

// file: bench/brss_top_tb_top.sv
// self-checking bench for the reset strap and select block
`timescale 1ns/100ps
module brss_top_tb_top;
  logic clk = 1'b0, rst = 1'b1, pci_reset_n = 1'b0, local_reset_input_n = 1'b1;
  logic hot_swap_good_n = 1'b1, software_reset_bit = 1'b0, burst_data_strap = 1'b1;
  logic transfer_size_bit_one = 1'b1, eeprom_load_strap = 1'b1, master_enable_strap = 1'b1;
  logic arbiter_enable_strap = 1'b1, host_link_off_strap = 1'b1, link_off_clear = 1'b0;
  logic initiator_enable_write = 1'b0, initiator_enable_value = 1'b0;
  // board fits an eeprom, so its load strap is held high above
  logic eeprom_fitted = 1'b1;
  logic [1:0]  test_config_strap = 2'h0;
  logic        cycle_start, burst_last, register_chip_select_n, window_chip_select_n;
  logic        image_select, address_strobe_input, first_size_ack_input, cycle_ack_n;
  logic        local_reset_output_n, initiator_enable_bit, link_off_flag, pci_target_retry;
  logic        outputs_float, nand_tree_mode, reg_burst_error;
  logic [31:0] local_addr, target_addr;
  brss_pkg::brss_strap_type  strap_state;
  brss_pkg::brss_target_type target_sel;
  int n_fail = 0, tests_run = 0, w;
  always #12.5 clk = ~clk;
  brss_top u_brss_top (.*);
  brss_cpu_model u_brss_cpu_model (.*);
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one decoded cycle, judged on its delay, routing and address
  task automatic cyc(input logic r, input logic i, input logic [31:0] a, input logic [1:0] s);
    u_brss_cpu_model.run(r, i, a, w);
    chk(w >= 4 && w <= 5, 1'b1);
    chk(target_sel, s);
    chk(target_addr, a);
    chk(reg_burst_error, 1'b0);
  endtask : cyc
  task automatic results;
    $display("checks %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  // a hang is cut short well after the sequence should have ended
  initial begin
    #(25 * 4000);
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end
  initial begin
    tick(12);
    rst <= 1'b0;
    tick(1);
    chk({cycle_ack_n, local_reset_output_n}, 2'h2);
    pci_reset_n <= 1'b1;
    tick(3);
    chk(strap_state, 7'h67);
    chk({initiator_enable_bit, link_off_flag, pci_target_retry}, 3'h7);
    chk({local_reset_output_n, outputs_float, nand_tree_mode}, 3'h4);
    // pins move in normal running; nothing captured may follow them
    {burst_data_strap, arbiter_enable_strap, host_link_off_strap, master_enable_strap} <= 4'h0;
    test_config_strap <= 2'h2;
    tick(3);
    chk(strap_state, 7'h67);
    link_off_clear <= 1'b1;
    tick(1);
    link_off_clear <= 1'b0;
    tick(3);
    chk({link_off_flag, pci_target_retry}, 2'h0);
    cyc(1'b1, 1'b0, 32'h0000_0010, brss_pkg::BRSS_SEL_REGS);
    cyc(1'b0, 1'b0, 32'h8000_0004, brss_pkg::BRSS_SEL_IMAGE0);
    cyc(1'b0, 1'b1, 32'hffff_fffc, brss_pkg::BRSS_SEL_IMAGE1);
    software_reset_bit <= 1'b1;
    tick(3);
    chk(local_reset_output_n, 1'b0);
    software_reset_bit <= 1'b0;
    hot_swap_good_n <= 1'b0;
    tick(3);
    chk({local_reset_output_n, strap_state & 7'h7b}, 8'hb0);
    chk(nand_tree_mode, 1'b1);
    local_reset_input_n <= 1'b0;
    tick(2);
    {test_config_strap, arbiter_enable_strap} <= 3'h1;
    local_reset_input_n <= 1'b1;
    tick(3);
    chk({strap_state.arbiter_enable, nand_tree_mode}, 2'h2);
    for (int v = 0; v < 2; v++) begin
      initiator_enable_value <= v[0];
      initiator_enable_write <= 1'b1;
      tick(1);
      initiator_enable_write <= 1'b0;
      tick(2);
      chk(initiator_enable_bit, v[0]);
    end
    // global reset with the master strap low must leave the initiator off
    pci_reset_n <= 1'b0;
    tick(2);
    chk({local_reset_output_n, cycle_ack_n}, 2'h1);
    pci_reset_n <= 1'b1;
    tick(3);
    chk(initiator_enable_bit, 1'b0);
    results();
  end
endmodule : brss_top_tb_top
